// file: verilog/sadc_regs.vh
// Register map, field positions and timing constants of the converter
`ifndef SADC_REGS_VH
`define SADC_REGS_VH


// Register indices and their APB byte addresses
`define SADC_IDX_RESULT   8'hD0
`define SADC_IDX_CTRL     8'hD1
`define SADC_ADDR_RESULT  {2'h0, `SADC_IDX_RESULT, 2'h0}
`define SADC_ADDR_CTRL    {2'h0, `SADC_IDX_CTRL, 2'h0}
`define SADC_ADDR_ISTAT   12'h348
`define SADC_ADDR_IMASK   12'h34C

// Control register fields
`define SADC_BIT_IRQ_EN   7
`define SADC_BIT_DONE     6
`define SADC_BIT_START    5
`define SADC_BIT_POWER    4
`define SADC_CTRL_RST     8'h40

// Interrupt status fields
`define SADC_IST_DONE     0
`define SADC_IST_ABORT    1

// Timing: pclk, oscillator, divider and conversion time
`define SADC_PCLK_KHZ     125000
`define SADC_OSC_KHZ      8000
`define SADC_OSC_DIV      12
`define SADC_CONV_NS      70000
`define SADC_TICK_CYC     (`SADC_PCLK_KHZ * `SADC_OSC_DIV / `SADC_OSC_KHZ)
`define SADC_CONV_TICKS   (`SADC_CONV_NS * `SADC_OSC_KHZ / (`SADC_OSC_DIV * 1000000))
`define SADC_BIT_TICKS    (`SADC_CONV_TICKS / 8)
`define SADC_SAMPLE_TICKS (`SADC_CONV_TICKS - 8 * `SADC_BIT_TICKS)

`endif

// file: verilog/sadc_control.v
// APB register file and successive-approximation sequencer of the converter
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

`include "sadc_regs.vh"

module sadc_control (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    input  wire        comp_in,
    output reg  [7:0]  dac_code,
    output wire        adc_power,
    output wire        sample_en,
    output wire        conv_irq,
    output wire        irq
);

////////////////////////////////////////////////////////////////////////////////
// Constants

// Sequencer states
localparam [1:0] ST_IDLE   = 2'h0;
localparam [1:0] ST_SAMPLE = 2'h1;
localparam [1:0] ST_CONV   = 2'h2;

// Conversion clock divider and phase lengths
localparam integer TICK_LAST   = `SADC_TICK_CYC - 1;
localparam integer SAMPLE_LAST = `SADC_SAMPLE_TICKS - 1;
localparam integer BIT_LAST    = `SADC_BIT_TICKS - 1;

// Control register value after reset
localparam [7:0] CTRL_RST = `SADC_CTRL_RST;

////////////////////////////////////////////////////////////////////////////////
// Declarations

// Software-visible register bits
reg        irq_en_r;
reg        done_r;
reg        power_r;
reg  [7:0] result_r;
reg  [1:0] istat_r;
reg  [1:0] imask_r;

// Comparator synchroniser stages
reg        comp_s1_r;
reg        comp_s2_r;

// Sequencer state and counters
reg  [1:0] state_r;
reg  [7:0] tick_cnt_r;
reg  [2:0] slot_r;
reg  [2:0] bit_r;

// Bus decode and sequencer strobes
wire       apb_access;
wire       apb_write;
wire       wr_ctrl;
wire       wr_istat;
wire       wr_imask;
wire       start_wr;
wire       busy;
wire       tick_en;
wire       slot_end;
wire       finish;
wire       abort;
wire [7:0] bit_mask;
wire [7:0] trial_code;
wire [1:0] istat_set;
wire [7:0] ctrl_rd;

// Next values of the combinational processes
reg  [1:0] istat_nxt;
reg        done_nxt;
reg [31:0] rdata_nxt;
reg        rd_err_nxt;

////////////////////////////////////////////////////////////////////////////////
// APB decode

// Writes take effect in the access phase only
assign apb_access = psel & penable;
assign apb_write  = apb_access & pwrite;

// Register selects
assign wr_ctrl  = apb_write & (paddr == `SADC_ADDR_CTRL);
assign wr_istat = apb_write & (paddr == `SADC_ADDR_ISTAT);
assign wr_imask = apb_write & (paddr == `SADC_ADDR_IMASK);

// A one in the start position launches a conversion
assign start_wr = wr_ctrl & pwdata[`SADC_BIT_START];

// Read data is captured in setup, so no wait states
// The converter never stalls the bus, even mid-conversion
assign pready = 1'b1;

////////////////////////////////////////////////////////////////////////////////
// Comparator input synchroniser

// Comparator output is asynchronous to pclk
// Only the second stage feeds the decision logic
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        comp_s1_r <= 1'b0;
        comp_s2_r <= 1'b0;
    end else begin
        comp_s1_r <= comp_in;
        comp_s2_r <= comp_s1_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Conversion clock divider

// Oscillator/12 rate as a one-cycle enable
// The fractional tick length rounds down, so a run ends a little early
assign busy    = (state_r != ST_IDLE);
assign tick_en = busy & (tick_cnt_r == TICK_LAST[7:0]);

// Divider restarts with each conversion
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tick_cnt_r <= 8'h00;
    end else if (start_wr || !busy || tick_en) begin
        tick_cnt_r <= 8'h00;
    end else begin
        tick_cnt_r <= tick_cnt_r + 8'h01;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Successive approximation sequencer

// Current trial bit and the code kept after the decision
assign bit_mask   = 8'h01 << bit_r;
assign trial_code = comp_s2_r ? dac_code : (dac_code & ~bit_mask);

// End of a phase slot
assign slot_end = (state_r == ST_SAMPLE) ? (slot_r == SAMPLE_LAST[2:0])
                                         : (slot_r == BIT_LAST[2:0]);

// Last decision of a conversion that nothing has cut short
// A start written in the same cycle wins, as does a power bit already cleared, so no stale done
assign finish = ~start_wr & power_r & tick_en & slot_end &
                (state_r == ST_CONV) & (bit_r == 3'h0);

// Conversion thrown away by a restart or a power-down
assign abort = busy & (start_wr | ~power_r);

// Sampling phase shown to the analogue front end
assign sample_en = (state_r == ST_SAMPLE);

// Sample, then eight decisions, then idle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_r  <= ST_IDLE;
        slot_r   <= 3'h0;
        bit_r    <= 3'h7;
        dac_code <= 8'h00;
    end else if (start_wr) begin
        // Restart from scratch, even mid-conversion
        state_r  <= power_r ? ST_SAMPLE : ST_IDLE;
        slot_r   <= 3'h0;
        bit_r    <= 3'h7;
        dac_code <= 8'h00;
    end else if (!power_r) begin
        // Power-down stops the converter
        state_r  <= ST_IDLE;
        slot_r   <= 3'h0;
        bit_r    <= 3'h7;
        dac_code <= 8'h00;
    end else if (tick_en) begin
        case (state_r)
            ST_SAMPLE: begin
                if (slot_end) begin
                    state_r  <= ST_CONV;
                    slot_r   <= 3'h0;
                    bit_r    <= 3'h7;
                    dac_code <= 8'h80;
                end else begin
                    slot_r <= slot_r + 3'h1;
                end
            end
            ST_CONV: begin
                if (slot_end) begin
                    slot_r <= 3'h0;
                    if (bit_r == 3'h0) begin
                        // No continuous mode
                        state_r  <= ST_IDLE;
                        dac_code <= trial_code;
                    end else begin
                        bit_r    <= bit_r - 3'h1;
                        dac_code <= trial_code | (bit_mask >> 1);
                    end
                end else begin
                    slot_r <= slot_r + 3'h1;
                end
            end
            default: begin
                state_r <= ST_IDLE;
                slot_r  <= 3'h0;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Result register

// Loaded only by a completed conversion
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        result_r <= 8'h00;
    end else if (finish) begin
        result_r <= trial_code;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Control register

// Enable and power bits written by software
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        irq_en_r <= CTRL_RST[`SADC_BIT_IRQ_EN];
        power_r  <= CTRL_RST[`SADC_BIT_POWER];
    end else if (wr_ctrl) begin
        irq_en_r <= pwdata[`SADC_BIT_IRQ_EN];
        power_r  <= pwdata[`SADC_BIT_POWER];
    end
end

// Done flag next value: cleared by start, set by finish, never by a write
always @* begin
    done_nxt = done_r;
    if (start_wr) begin
        done_nxt = 1'b0;
    end else if (finish) begin
        done_nxt = 1'b1;
    end
end

// Done flag register
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        done_r <= CTRL_RST[`SADC_BIT_DONE];
    end else begin
        done_r <= done_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupts

// Converter interrupt line, pending while done and enabled
assign conv_irq = irq_en_r & done_r;

// Sticky event sources
// Bit 0 reports a finished conversion, bit 1 an abandoned one
assign istat_set = {abort, finish};

// Write one to clear; a new event wins over the clear
always @* begin
    istat_nxt = istat_r;
    if (wr_istat) begin
        istat_nxt = istat_r & ~pwdata[1:0];
    end
    istat_nxt = istat_nxt | istat_set;
end

// Sticky status register
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        istat_r <= 2'h0;
    end else begin
        istat_r <= istat_nxt;
    end
end

// Mask register of the same layout
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        imask_r <= 2'h0;
    end else if (wr_imask) begin
        imask_r <= pwdata[1:0];
    end
end

// Level interrupt, no gating by any wait state
assign irq = |(istat_r & imask_r);

// Power to the analogue section follows the power bit
assign adc_power = power_r;

////////////////////////////////////////////////////////////////////////////////
// APB read path

// Control register as software sees it; the start position reads zero
assign ctrl_rd = {irq_en_r, done_r, 1'b0, power_r, 4'h0};

// Read mux for the addressed register
always @* begin
    rdata_nxt  = 32'h00000000;
    rd_err_nxt = 1'b0;
    case (paddr)
        `SADC_ADDR_RESULT: begin
            rdata_nxt = {24'h000000, result_r};
        end
        `SADC_ADDR_CTRL: begin
            rdata_nxt = {24'h000000, ctrl_rd};
        end
        `SADC_ADDR_ISTAT: begin
            rdata_nxt = {30'h0, istat_r};
        end
        `SADC_ADDR_IMASK: begin
            rdata_nxt = {30'h0, imask_r};
        end
        default: begin
            rd_err_nxt = 1'b1;
        end
    endcase
end

// Read data and error captured in the setup phase
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata  <= 32'h00000000;
        pslverr <= 1'b0;
    end else if (psel && !penable) begin
        prdata  <= rdata_nxt;
        pslverr <= rd_err_nxt;
    end
end

endmodule // sadc_control

`default_nettype wire

// file: dv/sadc_control_chk.sv
// Port checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "sadc_regs.vh"
module sadc_control_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [7:0]  dac_code,
    input wire logic        adc_power,
    input wire logic        sample_en,
    input wire logic        conv_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed write to the control register
    sequence s_ctrl_wr;
        psel && penable && pwrite && paddr == `SADC_ADDR_CTRL;
    endsequence
    ////////////////////////////////////////////////////////////////
    chk_power_bit: assert property (s_ctrl_wr |=> adc_power == $past(pwdata[4]))
        else $error("power out of step");
    chk_start_run: assert property ((s_ctrl_wr ##0 (pwdata[5] && pwdata[4] && adc_power))
        |=> sample_en && !conv_irq)
        else $error("start not taken");
    chk_irq_masked: assert property ((s_ctrl_wr ##0 !pwdata[7]) |=> !conv_irq)
        else $error("masked interrupt seen");
    chk_reset_idle: assert property ($rose(presetn)
        |-> !adc_power && !conv_irq && !sample_en && dac_code == 8'h00)
        else $error("not idle after reset");
    chk_sample_dac: assert property (sample_en |-> dac_code == 8'h00)
        else $error("trial code while sampling");
    chk_sample_hold: assert property ($rose(sample_en) |-> sample_en [*8])
        else $error("sampling cut short");
    chk_first_trial: assert property (($fell(sample_en) && adc_power)
        |-> ##[0:2] dac_code == 8'h80)
        else $error("first trial not 80");
    chk_power_idle: assert property ($fell(adc_power)
        |-> ##[0:1] (!sample_en && dac_code == 8'h00))
        else $error("busy while powered down");
endmodule // sadc_control_chk

bind sadc_control sadc_control_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .dac_code(dac_code), .adc_power(adc_power), .sample_en(sample_en), .conv_irq(conv_irq));
`default_nettype wire

// file: dv/sadc_analog_model.sv
// Analogue source and comparator facing the converter
`timescale 1ns/1ps
`default_nettype none
module sadc_analog_model (
    input  wire logic       pclk,
    input  wire logic [7:0] ain,
    input  wire logic [7:0] dac_code,
    input  wire logic       adc_power,
    output var  logic       comp_in
);
    logic flip_r = 1'b0;
    // Unpowered comparator output wanders every cycle
    always @(posedge pclk) begin
        flip_r <= ~flip_r;
    end
    // A single selected input compared with the trial code
    assign comp_in = adc_power ? (ain >= dac_code) : flip_r;
endmodule // sadc_analog_model
`default_nettype wire

// file: dv/tb_sar_adc_control.sv
// Self-checking bench: APB traffic against the comparator model
`timescale 1ns/1ps
`default_nettype none
`include "sadc_regs.vh"
module tb_sar_adc_control;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        comp_in, adc_power, sample_en, conv_irq, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  dac_code, ain;
    logic [32:0] exp_q[$];
    int          n_mismatch = 0;
    int          check_count = 0;
    int          i;
    ////////////////////////////////////////////////////////////////
    sadc_control uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comp_in(comp_in), .dac_code(dac_code), .adc_power(adc_power),
        .sample_en(sample_en), .conv_irq(conv_irq), .irq(irq));
    sadc_analog_model u_src (.pclk(pclk), .ain(ain), .dac_code(dac_code),
        .adc_power(adc_power), .comp_in(comp_in));
    // Clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        check_count++;
        if (seen !== want) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic chk1(input logic seen, input logic want);
        check({32'h0, seen}, {32'h0, want});
    endtask
    task automatic final_report();
        $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] want);
        exp_q.push_back(want);
        apb(1'b0, a, 32'h0);
    endtask
    // Waits for end of conversion and checks how long it took
    task automatic wait_done();
        int n;
        n = 0;
        while (conv_irq !== 1'b1 && n < 9000) begin
            @(posedge pclk);
            n++;
        end
        chk1(n > 8590 && n < 8610, 1'b1);
    endtask
    // Each completed read is matched with the oldest expectation
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check({pslverr, prdata}, exp_q.pop_front());
        end
    end
    // Watchdog
    initial begin
        repeat (60000) @(posedge pclk);
        n_mismatch++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h7343c54c));
        {psel, penable, pwrite, paddr, pwdata, ain} = '0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(`SADC_ADDR_CTRL, 33'h40);
        rd(`SADC_ADDR_ISTAT, 33'h0);
        rd(12'h000, 33'h1_0000_0000);
        apb(1'b1, `SADC_ADDR_CTRL, 32'h90);
        // Full conversions, mask off then on
        for (i = 0; i < 2; i++) begin
            ain <= i ? 8'($urandom) : 8'hFF;
            apb(1'b1, `SADC_ADDR_IMASK, 32'(i));
            apb(1'b1, `SADC_ADDR_CTRL, 32'hB0);
            rd(`SADC_ADDR_CTRL, 33'h90);
            wait_done();
            rd(`SADC_ADDR_CTRL, 33'hD0);
            apb(1'b1, `SADC_ADDR_RESULT, 32'h0);
            rd(`SADC_ADDR_RESULT, {25'h0, ain});
            apb(1'b1, `SADC_ADDR_CTRL, 32'h10);
            rd(`SADC_ADDR_CTRL, 33'h50);
            @(negedge pclk);
            chk1(conv_irq, 1'b0);
            chk1(irq, i[0]);
            apb(1'b1, `SADC_ADDR_ISTAT, 32'h1);
            apb(1'b1, `SADC_ADDR_CTRL, 32'h90);
            @(negedge pclk);
            chk1(irq, 1'b0);
            chk1(conv_irq, 1'b1);
        end
        // Restart in mid-conversion
        apb(1'b1, `SADC_ADDR_CTRL, 32'hB0);
        repeat (3000) @(posedge pclk);
        ain <= 8'h5A;
        apb(1'b1, `SADC_ADDR_CTRL, 32'hB0);
        rd(`SADC_ADDR_ISTAT, 33'h2);
        wait_done();
        rd(`SADC_ADDR_RESULT, 33'h5A);
        apb(1'b1, `SADC_ADDR_ISTAT, 32'h3);
        // Power drop aborts; unpowered start does nothing
        apb(1'b1, `SADC_ADDR_CTRL, 32'hB0);
        repeat (100) @(posedge pclk);
        apb(1'b1, `SADC_ADDR_CTRL, 32'h80);
        rd(`SADC_ADDR_ISTAT, 33'h2);
        apb(1'b1, `SADC_ADDR_CTRL, 32'hA0);
        repeat (9000) @(posedge pclk);
        rd(`SADC_ADDR_CTRL, 33'h80);
        // Reset during a conversion
        apb(1'b1, `SADC_ADDR_CTRL, 32'hB0);
        repeat (50) @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(`SADC_ADDR_CTRL, 33'h40);
        @(negedge pclk);
        chk1(adc_power, 1'b0);
        final_report();
    end
endmodule // tb_sar_adc_control
`default_nettype wire
